// ---- design/dual_timer_cc_array.sv ----
// capture/compare array of sixteen channels on two reloadable time bases, apb slave
// Function
// [R1] sixteen channels, one-cycle or eight-cycle resolution
// [R2] two independent 16-bit timers with reload registers
// [R3] timer clock: prescaled sysclk or timer-six overflow
// [R4] timers may count external input events
// [R5] each channel picks timer and capture/compare
// [R6] one pin per channel, input or output
// [R7] capture latches allocated timer on pin event
// [R8] each capture raises its channel interrupt
// [R9] capture edge: rising, falling or both
// [R10] compare channels match continuously against timer
// [R11] mode 0: interrupt on every match
// [R12] mode 1: pin toggles on every match
// [R13] mode 2: interrupt on first match per period; code loses a match on the reload value after a hit in the previous period
// [R14] mode 3: pin high on match, low on overflow; code loses a match on the reload value after a hit in the previous period
// [R15] double register: two channels toggle one pin
// [R16] single-event option stops after one edge/pulse; code stops compare pulses only, captures ignore it
// [R17] timer-six overflow usable by both timers
// [R18] overflow reloads timer from its reload register
// [R19] single-event option clears itself after firing
`timescale 1ns/1ps
module dual_timer_cc_array
   import dual_timer_cc_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [ADDR_W-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic [NUM_CH-1:0] i_cc_pin,
   input wire logic [NUM_TMR-1:0] i_ext_cnt,
   input wire logic i_gp_timer_six_ovf,
   output logic [NUM_CH-1:0] o_cc_pin,
   output logic [NUM_CH-1:0] o_cc_oe_n,
   output logic o_irq
);

   // single-cycle pulse when a source tick is due
   function automatic logic src_tick(input logic [SRC_W-1:0] src, input logic [PRE_W-1:0] pre,
                                     input logic stag, input logic six, input logic ext);
      logic t;
      t = 1'b0;
      unique case (src_t'(src))
         SRC_DIV1: t = stag ? (pre[2:0] == PRE_DIV8[2:0]) : 1'b1;
         SRC_DIV8: t = (pre[2:0] == PRE_DIV8[2:0]);
         SRC_DIV64: t = (pre[5:0] == PRE_DIV64[5:0]);
         SRC_DIV512: t = (pre == PRE_DIV512);
         SRC_GPT6: t = six;
         SRC_EXT: t = ext;
         SRC_RSV6: t = 1'b0;
         SRC_RSV7: t = 1'b0;
      endcase
      return t;
   endfunction : src_tick

   // compare modes that act on the pin
   function automatic logic pin_mode(input mode_t m);
      return (m == MODE_CMP1) || (m == MODE_CMP3);
   endfunction : pin_mode

   // apb side
   logic pready_r; // answer strobe, high one cycle in the second access cycle
   logic pslverr_r; // unmapped or misaligned address
   logic [31:0] prdata_r; // read data latched with the answer
   logic [31:0] rd_mux; // combinational read value
   logic rd_err; // combinational address error
   logic acc; // completing transfer
   logic wr; // completing write
   logic [3:0] ch_idx; // channel index from address

   // control and state registers
   logic [NUM_TMR-1:0] run_r; // timer run bits
   logic [SRC_W-1:0] src_r [NUM_TMR]; // timer clock sources
   logic stag_r; // staggered operation
   logic [NUM_CH/2-1:0] dbl_r; // pair k with k+8 on pin k
   logic [ST_W-1:0] stat_r; // sticky events
   logic [ST_W-1:0] mask_r; // interrupt enables
   logic [CNT_W-1:0] cnt_r [NUM_TMR]; // timer counts
   logic [CNT_W-1:0] rel_r [NUM_TMR]; // reload values
   logic [NUM_TMR-1:0] step_r; // timer moved last cycle
   logic [NUM_TMR-1:0] ovf_r; // timer overflowed last cycle
   logic [PRE_W-1:0] pre_r; // free-running prescaler
   logic [NUM_TMR-1:0] ext_d_r; // previous external count level
   ch_cfg_t cfg_r [NUM_CH]; // channel configs
   logic [CNT_W-1:0] val_r [NUM_CH]; // channel capture/compare values
   logic [NUM_CH-1:0] pin_d_r; // previous pin level for edge detect
   logic [NUM_CH-1:0] hit_r; // mode 2/3 already hit this period
   logic [NUM_CH-1:0] done_r; // single event consumed
   logic [NUM_CH-1:0] pin_r; // compare output level
   logic [NUM_CH-1:0] oe_n_r; // output enable, low while driving
   logic irq_r; // interrupt level

   // combinational event terms
   logic [NUM_TMR-1:0] tick; // count tick per timer
   logic [NUM_CH-1:0] capt; // capture event
   logic [NUM_CH-1:0] fire; // compare action
   logic [ST_W-1:0] evt; // status set terms

   assign acc = i_psel & i_penable & pready_r;
   assign wr = acc & i_pwrite;
   assign ch_idx = i_paddr[5:2];

   // tick selection per timer; timer-six overflow feeds either timer
   always_comb
   begin
      for (int t = 0; t < NUM_TMR; t++)
      begin
         tick[t] = run_r[t] & src_tick(src_r[t], pre_r, stag_r, i_gp_timer_six_ovf, // R1 R3 R17
                                       i_ext_cnt[t] & ~ext_d_r[t]); // R4
      end
   end

   // prescaler and external count edge history
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         pre_r <= '0;
         ext_d_r <= '0;
      end
      else
      begin
         pre_r <= pre_r + 1'b1;
         ext_d_r <= i_ext_cnt;
      end
   end

   // timers: software load wins over a tick so a count write is never half-applied
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         for (int t = 0; t < NUM_TMR; t++)
         begin
            cnt_r[t] <= CNT_RST;
            rel_r[t] <= CNT_RST;
         end
         step_r <= '0;
         ovf_r <= '0;
      end
      else
      begin
         for (int t = 0; t < NUM_TMR; t++)
         begin
            step_r[t] <= 1'b0;
            ovf_r[t] <= 1'b0;
            if (wr && i_paddr == (t == 0 ? OFS_T0_REL : OFS_T1_REL))
            begin
               rel_r[t] <= i_pwdata[CNT_W-1:0];
            end
            if (wr && i_paddr == (t == 0 ? OFS_T0_CNT : OFS_T1_CNT))
            begin
               cnt_r[t] <= i_pwdata[CNT_W-1:0];
            end
            else if (tick[t])
            begin
               step_r[t] <= 1'b1; // R2
               if (cnt_r[t] == CNT_MAX)
               begin
                  cnt_r[t] <= rel_r[t]; // R18
                  ovf_r[t] <= 1'b1;
               end
               else
               begin
                  cnt_r[t] <= cnt_r[t] + 1'b1;
               end
            end
         end
      end
   end

   // control registers
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         run_r <= '0;
         src_r[0] <= SRC_DIV1;
         src_r[1] <= SRC_DIV1;
         stag_r <= 1'b0;
         dbl_r <= '0;
         mask_r <= '0;
      end
      else if (wr)
      begin
         if (i_paddr == OFS_TCTRL)
         begin
            run_r <= {i_pwdata[TC_RUN1], i_pwdata[TC_RUN0]};
            src_r[0] <= i_pwdata[TC_SRC0 +: SRC_W];
            src_r[1] <= i_pwdata[TC_SRC1 +: SRC_W];
            stag_r <= i_pwdata[TC_STAG];
         end
         if (i_paddr == OFS_DBL)
         begin
            dbl_r <= i_pwdata[NUM_CH/2-1:0];
         end
         if (i_paddr == OFS_IRQ_MASK)
         begin
            mask_r <= i_pwdata[ST_W-1:0];
         end
      end
   end

   // per-channel event detection; a match counts only in the cycle after the timer moved
   always_comb
   begin
      for (int n = 0; n < NUM_CH; n++)
      begin
         capt[n] = 1'b0;
         fire[n] = 1'b0;
         unique case (cfg_r[n].mode)
            MODE_OFF: ;
            MODE_CAP_RISE: capt[n] = i_cc_pin[n] & ~pin_d_r[n]; // R9
            MODE_CAP_FALL: capt[n] = ~i_cc_pin[n] & pin_d_r[n]; // R9
            MODE_CAP_BOTH: capt[n] = i_cc_pin[n] ^ pin_d_r[n]; // R9
            MODE_CMP0, MODE_CMP1:
               fire[n] = step_r[cfg_r[n].tsel] & (cnt_r[cfg_r[n].tsel] == val_r[n]) // R10 R11 R12
                         & ~done_r[n]; // R16
            MODE_CMP2, MODE_CMP3:
               fire[n] = step_r[cfg_r[n].tsel] & (cnt_r[cfg_r[n].tsel] == val_r[n]) // R10
                         & ~done_r[n] & ~hit_r[n]; // R13 R14
         endcase
      end
   end

   // channel config and values; a capture wins over a software value write
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         for (int n = 0; n < NUM_CH; n++)
         begin
            cfg_r[n] <= CFG_RST;
            val_r[n] <= CNT_RST;
         end
         pin_d_r <= '0;
         hit_r <= '0;
         done_r <= '0;
      end
      else
      begin
         pin_d_r <= i_cc_pin;
         for (int n = 0; n < NUM_CH; n++)
         begin
            // timer allocation and mode per channel
            if (wr && i_paddr[ADDR_W-1:6] == OFS_CH_CFG[ADDR_W-1:6] && ch_idx == n[3:0])
            begin
               cfg_r[n] <= ch_cfg_t'(i_pwdata[CF_SE:CF_MODE]); // R5
               if (i_pwdata[CF_SE])
               begin
                  done_r[n] <= 1'b0; // re-arm single event
               end
            end
            if (fire[n] && cfg_r[n].se)
            begin
               cfg_r[n].se <= 1'b0; // R19
               done_r[n] <= 1'b1; // R16
            end
            if (capt[n])
            begin
               val_r[n] <= cnt_r[cfg_r[n].tsel]; // R7
            end
            else if (wr && i_paddr[ADDR_W-1:6] == OFS_CH_VAL[ADDR_W-1:6] && ch_idx == n[3:0])
            begin
               val_r[n] <= i_pwdata[CNT_W-1:0];
            end
            // period latch: the overflow clears it one cycle late, so after a hit a match on the reload value is lost
            if (fire[n])
            begin
               hit_r[n] <= 1'b1; // R13 R14
            end
            else if (ovf_r[cfg_r[n].tsel])
            begin
               hit_r[n] <= 1'b0;
            end
         end
      end
   end

   // pin drivers; second channel of a pair releases its own pin
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         pin_r <= '0;
         oe_n_r <= '1;
      end
      else
      begin
         for (int n = 0; n < NUM_CH; n++)
         begin
            if (n < NUM_CH / 2 && dbl_r[n % (NUM_CH / 2)])
            begin
               oe_n_r[n] <= 1'b0; // R6
               if (fire[n] || fire[(n + NUM_CH / 2) % NUM_CH])
               begin
                  pin_r[n] <= ~pin_r[n]; // R15
               end
            end
            else if (n >= NUM_CH / 2 && dbl_r[n % (NUM_CH / 2)])
            begin
               oe_n_r[n] <= 1'b1;
            end
            else
            begin
               oe_n_r[n] <= ~pin_mode(cfg_r[n].mode); // R6
               if (cfg_r[n].mode == MODE_CMP1 && fire[n])
               begin
                  pin_r[n] <= ~pin_r[n]; // R12
               end
               else if (cfg_r[n].mode == MODE_CMP3 && fire[n])
               begin
                  pin_r[n] <= 1'b1; // R14
               end
               else if (cfg_r[n].mode == MODE_CMP3 && ovf_r[cfg_r[n].tsel])
               begin
                  pin_r[n] <= 1'b0; // R14
               end
            end
         end
      end
   end

   // status set terms: channel events and timer overflows
   always_comb
   begin
      evt = '0;
      evt[NUM_CH-1:0] = capt | fire; // R8 R11 R13
      evt[ST_OVF0] = ovf_r[0];
      evt[ST_OVF1] = ovf_r[1];
   end

   // sticky status, write one to clear; a new event in the clearing cycle survives
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         stat_r <= '0;
      end
      else if (wr && i_paddr == OFS_IRQ_STAT)
      begin
         stat_r <= (stat_r & ~i_pwdata[ST_W-1:0]) | evt;
      end
      else
      begin
         stat_r <= stat_r | evt;
      end
   end

   // interrupt level, one cycle behind the status
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         irq_r <= 1'b0;
      end
      else
      begin
         irq_r <= |(stat_r & mask_r);
      end
   end

   // read mux and address check
   always_comb
   begin
      rd_mux = RD_ZERO;
      rd_err = 1'b0;
      if (i_paddr[1:0] != 2'b00)
      begin
         rd_err = 1'b1;
      end
      else if (i_paddr[ADDR_W-1:6] == OFS_CH_CFG[ADDR_W-1:6])
      begin
         rd_mux[CF_SE:CF_MODE] = cfg_r[ch_idx];
      end
      else if (i_paddr[ADDR_W-1:6] == OFS_CH_VAL[ADDR_W-1:6])
      begin
         rd_mux[CNT_W-1:0] = val_r[ch_idx];
      end
      else
      begin
         unique case (i_paddr)
            OFS_TCTRL:
            begin
               rd_mux[TC_RUN0] = run_r[0];
               rd_mux[TC_SRC0 +: SRC_W] = src_r[0];
               rd_mux[TC_RUN1] = run_r[1];
               rd_mux[TC_SRC1 +: SRC_W] = src_r[1];
               rd_mux[TC_STAG] = stag_r;
            end
            OFS_T0_CNT: rd_mux[CNT_W-1:0] = cnt_r[0];
            OFS_T0_REL: rd_mux[CNT_W-1:0] = rel_r[0];
            OFS_T1_CNT: rd_mux[CNT_W-1:0] = cnt_r[1];
            OFS_T1_REL: rd_mux[CNT_W-1:0] = rel_r[1];
            OFS_DBL: rd_mux[NUM_CH/2-1:0] = dbl_r;
            OFS_IRQ_STAT: rd_mux[ST_W-1:0] = stat_r;
            OFS_IRQ_MASK: rd_mux[ST_W-1:0] = mask_r;
            default: rd_err = 1'b1;
         endcase
      end
   end

   // apb answer: one wait state, so pready is a plain flop and never a path from the bus
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= RD_ZERO;
      end
      else
      begin
         pready_r <= i_psel & i_penable & ~pready_r;
         if (i_psel && i_penable && !pready_r)
         begin
            pslverr_r <= rd_err;
            prdata_r <= (i_pwrite || rd_err) ? RD_ZERO : rd_mux;
         end
         else
         begin
            pslverr_r <= 1'b0;
         end
      end
   end

   assign o_prdata = prdata_r;
   assign o_pready = pready_r;
   assign o_pslverr = pslverr_r;
   assign o_cc_pin = pin_r;
   assign o_cc_oe_n = oe_n_r;
   assign o_irq = irq_r;
endmodule : dual_timer_cc_array

// ---- design/dual_timer_cc_pkg.sv ----
// constants, types and register map of the dual time-base capture/compare array
package dual_timer_cc_pkg;
   // geometry
   localparam int NUM_CH = 16; // capture/compare channels
   localparam int NUM_TMR = 2; // time bases
   localparam int CNT_W = 16; // timer and channel register width
   localparam int ADDR_W = 12; // apb byte address width

   // register byte offsets
   localparam logic [ADDR_W-1:0] OFS_TCTRL = 12'h000; // timer run, clock source, stagger
   localparam logic [ADDR_W-1:0] OFS_T0_CNT = 12'h004; // timer 0 count
   localparam logic [ADDR_W-1:0] OFS_T0_REL = 12'h008; // timer 0 reload
   localparam logic [ADDR_W-1:0] OFS_T1_CNT = 12'h00c; // timer 1 count
   localparam logic [ADDR_W-1:0] OFS_T1_REL = 12'h010; // timer 1 reload
   localparam logic [ADDR_W-1:0] OFS_DBL = 12'h014; // double-register pair enables
   localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 12'h018; // sticky events, write one to clear
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 12'h01c; // interrupt enables, same layout
   localparam logic [ADDR_W-1:0] OFS_CH_CFG = 12'h040; // 16 channel config words
   localparam logic [ADDR_W-1:0] OFS_CH_VAL = 12'h080; // 16 channel value words
   localparam logic [ADDR_W-1:0] OFS_CH_SPAN = 12'h040; // bytes per channel register bank

   // timer control field positions
   localparam int TC_RUN0 = 0; // timer 0 run
   localparam int TC_SRC0 = 1; // timer 0 source, 3 bits
   localparam int TC_RUN1 = 8; // timer 1 run
   localparam int TC_SRC1 = 9; // timer 1 source, 3 bits
   localparam int TC_STAG = 16; // staggered operation
   localparam int SRC_W = 3;

   // channel config field positions
   localparam int CF_MODE = 0; // 3-bit mode
   localparam int CF_TSEL = 3; // timer allocation
   localparam int CF_SE = 4; // single-event option

   // status bits above the channel events
   localparam int ST_OVF0 = 16; // timer 0 overflow
   localparam int ST_OVF1 = 17; // timer 1 overflow
   localparam int ST_W = 18;

   // prescaler
   localparam int PRE_W = 9;
   localparam logic [PRE_W-1:0] PRE_DIV8 = 9'h007;
   localparam logic [PRE_W-1:0] PRE_DIV64 = 9'h03f;
   localparam logic [PRE_W-1:0] PRE_DIV512 = 9'h1ff;

   // reset values and count limit
   localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
   localparam logic [31:0] RD_ZERO = 32'h0000_0000;

   // timer count clock sources
   typedef enum logic [2:0] {
      SRC_DIV1 = 3'b000,
      SRC_DIV8 = 3'b001,
      SRC_DIV64 = 3'b010,
      SRC_DIV512 = 3'b011,
      SRC_GPT6 = 3'b100,
      SRC_EXT = 3'b101,
      SRC_RSV6 = 3'b110,
      SRC_RSV7 = 3'b111
   } src_t;

   // channel operating modes
   typedef enum logic [2:0] {
      MODE_OFF = 3'b000,
      MODE_CAP_RISE = 3'b001,
      MODE_CAP_FALL = 3'b010,
      MODE_CAP_BOTH = 3'b011,
      MODE_CMP0 = 3'b100,
      MODE_CMP1 = 3'b101,
      MODE_CMP2 = 3'b110,
      MODE_CMP3 = 3'b111
   } mode_t;

   // per-channel configuration word
   typedef struct packed {
      logic se;
      logic tsel;
      mode_t mode;
   } ch_cfg_t;

   localparam ch_cfg_t CFG_RST = '{se: 1'b0, tsel: 1'b0, mode: MODE_OFF};
endpackage : dual_timer_cc_pkg

// ---- sim/dual_timer_cc_array_sva.sv ----
// concurrent checks on the bus and pin ports of the capture/compare array
`timescale 1ns/1ps
module dual_timer_cc_array_sva
   import dual_timer_cc_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [ADDR_W-1:0] i_paddr,
   input wire logic [31:0] o_prdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic [NUM_CH-1:0] o_cc_pin,
   input wire logic [NUM_CH-1:0] o_cc_oe_n
);
   // misaligned, in the gap, or past the last channel value word
   logic bad_addr;
   assign bad_addr = (i_paddr[1:0] != 2'h0) || (i_paddr > OFS_IRQ_MASK && i_paddr < OFS_CH_CFG)
      || (i_paddr > OFS_CH_VAL + 12'h03c);

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);

   // the answer is a one-cycle pulse
   ready_pulse_a: assert property (o_pready |=> !o_pready) else $error("pready held");
   // one wait state, then the answer
   ready_wait_a: assert property (i_psel && i_penable && !$past(i_penable) |-> !o_pready ##1 o_pready)
      else $error("pready not on second access cycle");
   ready_phase_a: assert property (o_pready |-> i_psel && i_penable) else $error("pready outside access");
   ready_cause_a: assert property (o_pready |-> $past(i_penable) && !$past(o_pready))
      else $error("pready without prior access cycle");
   map_err_a: assert property (o_pready |-> o_pslverr == bad_addr) else $error("slverr disagrees with map");
   err_data_a: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0) else $error("bad error answer");
   wr_data_a: assert property (o_pready && i_pwrite |-> o_prdata == 32'h0) else $error("write returned data");
   // a pin level may only move while the channel drives it
   pin_driven_a: assert property (((o_cc_pin ^ $past(o_cc_pin)) & o_cc_oe_n & $past(o_cc_oe_n)) == 16'h0)
      else $error("undriven pin changed");
endmodule : dual_timer_cc_array_sva

bind dual_timer_cc_array dual_timer_cc_array_sva u_dual_timer_cc_array_sva (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
   .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_prdata(o_prdata),
   .o_pready(o_pready), .o_pslverr(o_pslverr), .o_cc_pin(o_cc_pin), .o_cc_oe_n(o_cc_oe_n));

// ---- sim/cc_pin_model.sv ----
// far-side pin levels and count events feeding the capture/compare array
`timescale 1ns/1ps
module cc_pin_model
   import dual_timer_cc_pkg::*;
(
   input wire logic i_clk,
   output logic [NUM_CH-1:0] o_pin,
   output logic [NUM_TMR-1:0] o_ext,
   output logic o_six
);
   int cyc; // free-running cycle count for the timer-six cadence
   initial
   begin
      o_pin = '0;
      o_ext = '0;
      o_six = 1'b0;
      cyc = 0;
   end
   // timer-six overflows come as one-cycle pulses on a fixed cadence
   always @(posedge i_clk)
   begin
      cyc <= cyc + 1;
      o_six <= (cyc % 37 == 36);
   end
   // one count event: held two cycles so the sampler cannot miss it
   task step(input int t);
      @(posedge i_clk);
      o_ext[t] <= 1'b1;
      repeat (2) @(posedge i_clk);
      o_ext[t] <= 1'b0;
      repeat (3) @(posedge i_clk);
   endtask : step
   // move one pin and give the capture time to land
   task set_pin(input int ch, input logic lvl);
      @(posedge i_clk);
      o_pin[ch] <= lvl;
      repeat (4) @(posedge i_clk);
   endtask : set_pin
endmodule : cc_pin_model

// ---- sim/tb_top.sv ----
// self-checking bench: apb map, compare modes on an event-driven timer, capture edges
`timescale 1ns/1ps
module tb_top
   import dual_timer_cc_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic pready, pslverr, six, irq;
   logic [NUM_CH-1:0] pin_in, pin_out, oe_n;
   logic [NUM_TMR-1:0] ext;
   int error_cnt = 0;
   int compares = 0;
   int cyc = 0;
   // reference model state for the channel under test
   mode_t m_mode;
   logic m_se, m_pin, m_lat, m_arm;
   logic [15:0] m_cnt;
   logic [31:0] m_st;
   int m_ch;
   int pre = 0, n_six, n_d8;
   logic gate = 1'b0;

   always #5 clk = ~clk;

   // bench copy of the free prescaler; six pulses and /8 ticks counted while the gate is open
   always @(posedge clk)
   begin
      pre <= rst ? 0 : pre + 1;
      if (gate)
      begin
         n_six += int'(six);
         n_d8 += int'(pre % 8 == 7);
      end
   end

   dual_timer_cc_array u_dual_timer_cc_array (.i_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_cc_pin(pin_in), .i_ext_cnt(ext), .i_gp_timer_six_ovf(six), .o_cc_pin(pin_out),
      .o_cc_oe_n(oe_n), .o_irq(irq));
   cc_pin_model u_cc_pin_model (.i_clk(clk), .o_pin(pin_in), .o_ext(ext), .o_six(six));

   task end_of_test;
      if (error_cnt == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_of_test

   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // one apb transfer, held until pready is seen at an edge
   task apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [31:0] r,
      output logic e);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
      chk("wr_err", 32'h0, 32'(e));
   endtask : wr

   task rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input string nm);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(nm, exp, r);
   endtask : rd

   task do_reset;
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
   endtask : do_reset

   // count events on timer 1, model reload and compare action, check the pin after each
   task steps(input int n);
      logic ovf;
      repeat (n)
      begin
         u_cc_pin_model.step(1);
         ovf = (m_cnt == 16'hffff);
         m_cnt = ovf ? 16'hfffa : m_cnt + 16'h1;
         if (ovf)
         begin
            m_st[ST_OVF1] = 1'b1;
            m_lat = 1'b0;
            if (m_mode == MODE_CMP3) m_pin = 1'b0;
         end
         // the period latch only holds back modes 2 and 3
         if (m_cnt == 16'hfffc && m_arm && !(m_lat && m_mode inside {MODE_CMP2, MODE_CMP3}))
         begin
            m_st[m_ch] = 1'b1;
            m_lat = 1'b1;
            m_arm = !m_se;
            if (m_mode == MODE_CMP1) m_pin = !m_pin;
            if (m_mode == MODE_CMP3) m_pin = 1'b1;
         end
         chk("cc_pin", 32'(m_pin), 32'(pin_out[m_ch]));
         chk("cc_oe_n", 32'(!(m_mode inside {MODE_CMP1, MODE_CMP3})), 32'(oe_n[m_ch]));
      end
   endtask : steps

   task stat_chk;
      rd(OFS_IRQ_STAT, m_st, "irq_stat");
      chk("irq", 32'(m_st[m_ch]), 32'(irq));
      wr(OFS_IRQ_STAT, 32'hffff_ffff);
      m_st = 32'h0;
   endtask : stat_chk

   task cmp_run(input mode_t m, input logic se);
      do_reset();
      m_mode = m;
      m_se = se;
      m_ch = $urandom % NUM_CH;
      m_cnt = 16'hfffa;
      m_pin = 1'b0;
      m_lat = 1'b0;
      m_arm = 1'b1;
      m_st = 32'h0;
      wr(OFS_T1_REL, 32'hfffa);
      wr(OFS_T1_CNT, 32'hfffa);
      wr(OFS_IRQ_MASK, 32'h1 << m_ch);
      wr(OFS_CH_VAL + 12'(4 * m_ch), 32'hfffc);
      wr(OFS_CH_CFG + 12'(4 * m_ch), 32'({se, 1'b1, m}));
      wr(OFS_TCTRL, 32'({SRC_EXT, 1'b1}) << TC_RUN1);
      steps(3);
      stat_chk();
      // pull the count back inside the same period to get a second match
      wr(OFS_T1_CNT, 32'hfffb);
      m_cnt = 16'hfffb;
      steps(1);
      stat_chk();
      steps(6);
      stat_chk();
      rd(OFS_T1_CNT, 32'(m_cnt), "t1_cnt");
      rd(OFS_CH_CFG + 12'(4 * m_ch), 32'({se & m_arm, 1'b1, m}), "ch_cfg");
   endtask : cmp_run

   // timer 0 held still so the captured value is known
   task cap_run(input mode_t m);
      logic [31:0] v, exp_v;
      logic hit;
      do_reset();
      m_ch = $urandom % NUM_CH;
      exp_v = 32'h0;
      wr(OFS_CH_CFG + 12'(4 * m_ch), 32'(m));
      for (int lvl = 1; lvl >= 0; lvl--)
      begin
         v = $urandom % 32'h10000;
         wr(OFS_T0_CNT, v);
         u_cc_pin_model.set_pin(m_ch, lvl[0]);
         hit = lvl[0] ? (m != MODE_CAP_FALL) : (m != MODE_CAP_RISE);
         if (hit) exp_v = v;
         rd(OFS_CH_VAL + 12'(4 * m_ch), exp_v, "cap_val");
         rd(OFS_IRQ_STAT, 32'(hit) << m_ch, "cap_stat");
         wr(OFS_IRQ_STAT, 32'hffff_ffff);
      end
   endtask : cap_run

   // pair on pin k: a match of either channel toggles it, the upper pin is released
   task dbl_run;
      do_reset();
      m_ch = $urandom % 8;
      wr(OFS_DBL, 32'h1 << m_ch);
      wr(OFS_CH_VAL + 12'(4 * m_ch), 32'h2);
      wr(OFS_CH_VAL + 12'(4 * m_ch + 32), 32'h4);
      wr(OFS_CH_CFG + 12'(4 * m_ch), 32'(MODE_CMP1));
      wr(OFS_CH_CFG + 12'(4 * m_ch + 32), 32'(MODE_CMP0));
      wr(OFS_TCTRL, 32'({SRC_EXT, 1'b1}));
      for (int i = 1; i < 6; i++)
      begin
         u_cc_pin_model.step(0);
         chk("dbl_pin", 32'(i == 2 || i == 3), 32'(pin_out[m_ch]));
         chk("dbl_oe_n", 32'h2, 32'({oe_n[m_ch + 8], oe_n[m_ch]}));
      end
   endtask : dbl_run

   // count sources over a gated window; the extra edge lets the counters settle
   task src_run(input src_t s0, input src_t s1, input logic stag);
      do_reset();
      n_six = 0;
      n_d8 = 0;
      wr(OFS_TCTRL, (32'(stag) << TC_STAG) | (32'({s1, 1'b1}) << TC_RUN1) | 32'({s0, 1'b1}));
      gate <= 1'b1;
      repeat (150) @(posedge clk);
      wr(OFS_TCTRL, 32'h0);
      gate <= 1'b0;
      @(posedge clk);
      rd(OFS_T0_CNT, 32'(s0 == SRC_GPT6 ? n_six : n_d8), "t0_src");
      rd(OFS_T1_CNT, 32'(s1 == SRC_GPT6 ? n_six : n_d8), "t1_src");
   endtask : src_run

   // hang guard far above the expected few thousand cycles
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         error_cnt++;
         end_of_test();
      end
   end

   initial
   begin
      logic [31:0] r;
      logic e;
      m_ch = $urandom(29634);
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      // every halfword address below 0x100: reset value zero, error only off the map
      for (int a = 0; a < 12'h100; a += 2)
      begin
         apb(1'b0, 12'(a), 32'h0, r, e);
         chk("reset_val", 32'h0, r);
         chk("slverr", 32'(a % 4 != 0 || (a > 12'h01c && a < 12'h040) || a > 12'h0bc), 32'(e));
      end
      apb(1'b1, 12'h020, 32'hffff_ffff, r, e);
      chk("wr_unmapped", 32'h1, 32'(e));
      for (int m = 4; m < 8; m++)
         for (int s = 0; s < 2; s++)
            cmp_run(mode_t'(m), s[0]);
      for (int m = 1; m < 4; m++)
         cap_run(mode_t'(m));
      dbl_run();
      src_run(SRC_GPT6, SRC_DIV8, 1'b0);
      src_run(SRC_DIV1, SRC_GPT6, 1'b1);
      end_of_test();
   end
endmodule : tb_top
